// ==== core/pbcr_regs.sv ====
// bridge control, interrupt pin and power management header registers
//
// Functional notes
// - bit16 enables poisoned TLP detect and report
// - bit17 gates error message forwarding upstream
// - bit18 sends ISA-aliased window I/O upstream
// - bit19 forwards legacy video memory range
// - video I/O 3B0-3BB, 3C0-3DF forwarded too
// - bit20 picks 10-bit or 16-bit decode
// - port 2 ignores video enable bits
// - bit22 drives downstream port reset
// - upstream bit22 resets every downstream port
// - bits 21, 23-31 read zero
// - interrupt pin byte read-only, resets 00h
// - management load may override pin value, downstream ports only
// - offset 80h byte0 reads 01h
// - upstream next pointer reads 9Ch
// - downstream next pointer reads 8Ch
// - offset 34h reads 80h
`timescale 1ns/1ns
module pbcr_regs
    import pbcr_pkg::*;
#(
    parameter bit IS_UPSTREAM = 1'b0,
    parameter int PORT_NUM    = 1,
    parameter int NUM_DS      = 4
) (
    // clock, reset, enable
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        ce,
    // axi4-lite write channels
    input  wire logic [11:0] s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    // axi4-lite read channels
    input  wire logic [11:0] s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready,
    // management override of interrupt pin
    input  wire logic        mgmt_pin_load,
    input  wire logic [7:0]  mgmt_pin_value,
    // transaction decode requests
    input  wire logic        io_valid,
    input  wire logic [31:0] io_addr,
    input  wire logic        io_in_window,
    input  wire logic        mem_valid,
    input  wire logic [31:0] mem_addr,
    input  wire logic        poison_seen,
    input  wire logic        err_msg_in,
    // decode results and port controls
    output logic             io_fwd_up,
    output logic             io_fwd_down,
    output logic             vga_fwd,
    output logic             poison_report,
    output logic             err_msg_fwd,
    output logic [NUM_DS-1:0] port_reset,
    output logic             irq
);
    localparam int RST_W = IS_UPSTREAM ? NUM_DS : 1;

    pbcr_bctl_t              bctl;
    logic [7:0]              int_line;
    logic [7:0]              int_pin;
    logic [PBCR_NUM_EV-1:0]  irq_stat;
    logic [PBCR_NUM_EV-1:0]  irq_mask;
    logic [11:0]             aw_addr;
    logic                    aw_full;
    logic [31:0]             w_data;
    logic [3:0]              w_strb;
    logic                    w_full;
    logic                    sbr_q;

    // video I/O hit: low ten bits always, upper six only for 16-bit decode
    function automatic logic vga_io_hit(input logic [31:0] a,
                                        input logic dec16);
        logic lo;
        lo = (a[9:0] >= PBCR_VGA_IO_A_LO && a[9:0] <= PBCR_VGA_IO_A_HI) ||
             (a[9:0] >= PBCR_VGA_IO_B_LO && a[9:0] <= PBCR_VGA_IO_B_HI);
        return lo && (a[31:16] == 16'h0000) &&
               (!dec16 || a[15:10] == 6'h00);
    endfunction

    // register address match, used by write and read paths
    function automatic logic is_mapped(input logic [11:0] a);
        return a == PBCR_CAP_PTR_OFF || a == PBCR_INT_OFF ||
               a == PBCR_PM_CAP_OFF || a == PBCR_IRQ_STAT_OFF ||
               a == PBCR_IRQ_MASK_OFF;
    endfunction

    // port 2 has no video forwarding, so the bits are masked out
    wire logic vga_ok     = (PORT_NUM != PBCR_RESERVED_PORT);
    wire logic vga_en_eff = bctl.vga_en && vga_ok;
    wire logic vga16_eff  = bctl.vga16 && vga_ok;

    // combinational decode of the forwarding requests
    wire logic io_low64k  = (io_addr[31:16] == 16'h0000);
    wire logic isa_alias  = io_low64k && (io_addr[9:8] != 2'h0);
    wire logic isa_up     = bctl.isa_en && io_in_window && isa_alias;
    wire logic vga_io     = vga_en_eff &&
                            vga_io_hit(io_addr, vga16_eff);
    wire logic vga_mem    = vga_en_eff && mem_addr >= PBCR_VGA_MEM_LO &&
                            mem_addr <= PBCR_VGA_MEM_HI;
    wire logic next_io_up   = io_valid && isa_up;
    wire logic next_io_down = io_valid && ((io_in_window && !isa_up) ||
                              vga_io);
    wire logic next_vga     = (mem_valid && vga_mem) || (io_valid && vga_io);
    wire logic next_poison  = poison_seen && bctl.poison_en;
    wire logic next_errfwd  = err_msg_in && bctl.err_fwd_en;

    // write side decode
    wire logic wr_go   = aw_full && w_full && !s_bvalid;
    wire logic wr_bctl = wr_go && aw_addr == PBCR_INT_OFF;
    wire logic wr_stat = wr_go && aw_addr == PBCR_IRQ_STAT_OFF && w_strb[0];
    wire logic wr_mask = wr_go && aw_addr == PBCR_IRQ_MASK_OFF && w_strb[0];
    wire logic hot_rise = bctl.sbr && !sbr_q;

    // byte-lane update of the writable bridge control bits
    wire pbcr_bctl_t bctl_wr = '{
        sbr:        w_data[PBCR_SBR_BIT],
        vga16:      w_data[PBCR_VGA16_BIT] && vga_ok,
        vga_en:     w_data[PBCR_VGA_BIT] && vga_ok,
        isa_en:     w_data[PBCR_ISA_BIT],
        err_fwd_en: w_data[PBCR_ERRFWD_BIT],
        poison_en:  w_data[PBCR_POISON_BIT]
    };
    wire pbcr_bctl_t next_bctl = (wr_bctl && w_strb[2]) ? bctl_wr : bctl;

    // sticky events: a new event beats a same-cycle clear
    wire logic [PBCR_NUM_EV-1:0] ev_now = {hot_rise, next_errfwd,
                                           next_poison};
    wire logic [PBCR_NUM_EV-1:0] next_stat =
        (irq_stat & ~(wr_stat ? w_data[PBCR_NUM_EV-1:0] : '0)) | ev_now;

    // read data mux; hardwired-zero bits are tied to constant zeros
    wire logic [11:0] rd_a = {s_araddr[11:2], 2'h0}; // same word as writes
    wire logic [7:0]  bctl_byte = {1'b0, bctl.sbr, 1'b0, bctl.vga16,
                                   bctl.vga_en, bctl.isa_en,
                                   bctl.err_fwd_en, bctl.poison_en};
    wire logic [7:0]  next_ptr = IS_UPSTREAM ? PBCR_NEXT_UP
                                             : PBCR_NEXT_DOWN;
    wire logic [31:0] rd_mux =
        (rd_a == PBCR_CAP_PTR_OFF)  ? {24'h000000,
                                       PBCR_CAP_PTR_VAL} :
        (rd_a == PBCR_INT_OFF)      ? {8'h00, bctl_byte, int_pin,
                                       int_line} :
        (rd_a == PBCR_PM_CAP_OFF)   ? {16'h0000, next_ptr,
                                       PBCR_PM_CAP_ID} :
        (rd_a == PBCR_IRQ_STAT_OFF) ? {29'h0, irq_stat} :
        (rd_a == PBCR_IRQ_MASK_OFF) ? {29'h0, irq_mask} : 32'h00000000;

    // write address and data are held independently, in any order
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            aw_full   <= 1'b0;
            w_full    <= 1'b0;
            aw_addr   <= 12'h000;
            w_data    <= 32'h00000000;
            w_strb    <= 4'h0;
            s_awready <= 1'b1;
            s_wready  <= 1'b1;
            s_bvalid  <= 1'b0;
            s_bresp   <= PBCR_RESP_OK;
        end else if (ce) begin
            if (s_awvalid && s_awready) begin
                aw_full   <= 1'b1;
                aw_addr   <= {s_awaddr[11:2], 2'h0};
                s_awready <= 1'b0;
            end
            if (s_wvalid && s_wready) begin
                w_full   <= 1'b1;
                w_data   <= s_wdata;
                w_strb   <= s_wstrb;
                s_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_full   <= 1'b0;
                w_full    <= 1'b0;
                s_bvalid  <= 1'b1;
                s_bresp   <= is_mapped(aw_addr) ? PBCR_RESP_OK
                                                : PBCR_RESP_ERR;
            end
            if (s_bvalid && s_bready) begin
                s_bvalid  <= 1'b0;
                s_awready <= 1'b1;
                s_wready  <= 1'b1;
            end
        end
    end

    // register state; only strobed writable lanes change
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            bctl     <= PBCR_BCTL_RST;
            int_line <= PBCR_INT_LINE_RST;
            int_pin  <= PBCR_INT_PIN_RST;
            irq_stat <= '0;
            irq_mask <= '0;
            sbr_q    <= 1'b0;
        end else if (ce) begin
            bctl     <= next_bctl;
            sbr_q    <= bctl.sbr;
            irq_stat <= next_stat;
            if (wr_bctl && w_strb[0]) begin
                int_line <= w_data[7:0];
            end
            if (mgmt_pin_load && !IS_UPSTREAM) begin
                int_pin <= mgmt_pin_value;
            end
            if (wr_mask) begin
                irq_mask <= w_data[PBCR_NUM_EV-1:0];
            end
        end
    end

    // read channel answers one cycle after the address is taken
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s_arready <= 1'b1;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h00000000;
            s_rresp   <= PBCR_RESP_OK;
        end else if (ce) begin
            if (s_arvalid && s_arready) begin
                s_arready <= 1'b0;
                s_rvalid  <= 1'b1;
                s_rdata   <= rd_mux;
                s_rresp   <= is_mapped(rd_a) ? PBCR_RESP_OK
                                             : PBCR_RESP_ERR;
            end else if (s_rvalid && s_rready) begin
                s_rvalid  <= 1'b0;
                s_arready <= 1'b1;
            end
        end
    end

    // registered decode outputs
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            io_fwd_up     <= 1'b0;
            io_fwd_down   <= 1'b0;
            vga_fwd       <= 1'b0;
            poison_report <= 1'b0;
            err_msg_fwd   <= 1'b0;
            irq           <= 1'b0;
        end else if (ce) begin
            io_fwd_up     <= next_io_up;
            io_fwd_down   <= next_io_down;
            vga_fwd       <= next_vga;
            poison_report <= next_poison;
            err_msg_fwd   <= next_errfwd;
            irq           <= |(next_stat & irq_mask);
        end
    end

    // port reset follows the bit level; upstream fans out to all ports
    genvar gi;
    generate
        for (gi = 0; gi < NUM_DS; gi++) begin : g_rst
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    port_reset[gi] <= 1'b0;
                end else if (ce) begin
                    port_reset[gi] <= (gi < RST_W) &&
                                      next_bctl.sbr;
                end
            end
        end
    endgenerate

    // one clock domain, so one default clock and reset for every check
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    // decode outputs follow the enables of the cycle before
    chk_poison_gate: assert property (
        ce && poison_seen && !bctl.poison_en |=> !poison_report)
        else $error("poison reported while off");
    chk_err_forward: assert property (
        ce && err_msg_in |=> err_msg_fwd == $past(bctl.err_fwd_en))
        else $error("error forward gate wrong");
    chk_isa_upstream: assert property (
        ce && io_valid && io_in_window && bctl.isa_en && isa_alias
        |=> io_fwd_up && !io_fwd_down)
        else $error("isa alias not sent upstream");
    chk_vga_memory: assert property (
        ce && mem_valid && vga_en_eff && mem_addr == PBCR_VGA_MEM_HI
        |=> vga_fwd)
        else $error("video memory not forwarded");
    chk_port_two: assert property (
        PORT_NUM == PBCR_RESERVED_PORT |-> !vga_fwd && !bctl.vga_en)
        else $error("port 2 acted on video bits");

    // port reset mirrors the bit level, set and cleared alike
    chk_hot_reset: assert property (
        port_reset[0] == bctl.sbr)
        else $error("port reset not following bit");
    chk_reset_fanout: assert property (
        port_reset == (IS_UPSTREAM ? {NUM_DS{bctl.sbr}}
                                   : {{(NUM_DS-1){1'b0}}, bctl.sbr}))
        else $error("port reset fan-out wrong");

    // read data of the fixed and hardwired fields
    chk_ro_zero: assert property (
        s_arvalid && s_arready && ce && rd_a == PBCR_INT_OFF
        |=> s_rdata[31:23] == 9'h000 && !s_rdata[21])
        else $error("hardwired bits not zero");
    chk_cap_header: assert property (
        s_arvalid && s_arready && ce && rd_a == PBCR_PM_CAP_OFF
        |=> s_rdata[15:0] == {next_ptr, PBCR_PM_CAP_ID})
        else $error("capability header wrong");
    chk_cap_pointer: assert property (
        s_arvalid && s_arready && ce && rd_a == PBCR_CAP_PTR_OFF
        |=> s_rdata == {24'h000000, PBCR_CAP_PTR_VAL})
        else $error("capability pointer wrong");

    // the pin byte moves only on a management load, never on a bus write
    chk_pin_fixed: assert property (
        ce && !mgmt_pin_load |=> $stable(int_pin))
        else $error("interrupt pin changed by a write");
    chk_pin_load: assert property (
        ce && mgmt_pin_load && !IS_UPSTREAM
        |=> int_pin == $past(mgmt_pin_value))
        else $error("interrupt pin load lost");

    // status bits stay until written off; interrupt follows the mask
    chk_stat_sticky: assert property (
        ce && !wr_stat |=> (irq_stat & $past(irq_stat)) == $past(irq_stat))
        else $error("status bit lost without a clear");
    chk_irq_level: assert property (
        ce && |(next_stat & irq_mask) |=> irq)
        else $error("interrupt not raised");

    // a low enable must freeze every flop, outputs included
    chk_ce_freeze: assert property (
        !ce |=> $stable(bctl) && $stable(port_reset) && $stable(irq) &&
        $stable(vga_fwd) && $stable(s_rvalid))
        else $error("state moved while enable low");

    cov_hot_reset: cover property (bctl.sbr ##1 port_reset[0]);
    cov_isa_up: cover property (io_fwd_up);
    cov_irq: cover property (irq ##[1:20] !irq);
    cov_vga_io: cover property (vga_fwd && io_fwd_down);
    cov_pin_load: cover property (mgmt_pin_load ##1 $changed(int_pin));
endmodule // pbcr_regs

// ==== shared/pbcr_pkg.sv ====
// shared constants and types for the bridge control register bank
package pbcr_pkg;
    // register byte addresses
    localparam logic [11:0] PBCR_CAP_PTR_OFF  = 12'h034;
    localparam logic [11:0] PBCR_INT_OFF      = 12'h03C;
    localparam logic [11:0] PBCR_PM_CAP_OFF   = 12'h080;
    localparam logic [11:0] PBCR_IRQ_STAT_OFF = 12'h100;
    localparam logic [11:0] PBCR_IRQ_MASK_OFF = 12'h104;
    // fixed values
    localparam logic [7:0] PBCR_CAP_PTR_VAL = 8'h80;
    localparam logic [7:0] PBCR_PM_CAP_ID   = 8'h01;
    localparam logic [7:0] PBCR_NEXT_UP     = 8'h9C;
    localparam logic [7:0] PBCR_NEXT_DOWN   = 8'h8C;
    localparam logic [7:0] PBCR_INT_PIN_RST = 8'h00;
    localparam logic [7:0] PBCR_INT_LINE_RST = 8'h00;
    // bridge control bit positions within the 32-bit word
    localparam int PBCR_POISON_BIT = 16;
    localparam int PBCR_ERRFWD_BIT = 17;
    localparam int PBCR_ISA_BIT    = 18;
    localparam int PBCR_VGA_BIT    = 19;
    localparam int PBCR_VGA16_BIT  = 20;
    localparam int PBCR_SBR_BIT    = 22;
    // legacy decode ranges
    localparam logic [31:0] PBCR_VGA_MEM_LO = 32'h000A_0000;
    localparam logic [31:0] PBCR_VGA_MEM_HI = 32'h000B_FFFF;
    localparam logic [9:0]  PBCR_VGA_IO_A_LO = 10'h3B0;
    localparam logic [9:0]  PBCR_VGA_IO_A_HI = 10'h3BB;
    localparam logic [9:0]  PBCR_VGA_IO_B_LO = 10'h3C0;
    localparam logic [9:0]  PBCR_VGA_IO_B_HI = 10'h3DF;
    localparam int PBCR_RESERVED_PORT = 2;
    // interrupt status bits
    localparam int PBCR_EV_POISON = 0;
    localparam int PBCR_EV_ERRFWD = 1;
    localparam int PBCR_EV_HOTRST = 2;
    localparam int PBCR_NUM_EV    = 3;
    localparam logic [1:0] PBCR_RESP_OK  = 2'h0;
    localparam logic [1:0] PBCR_RESP_ERR = 2'h2;

    // writable bridge control fields
    typedef struct packed {
        logic sbr;
        logic vga16;
        logic vga_en;
        logic isa_en;
        logic err_fwd_en;
        logic poison_en;
    } pbcr_bctl_t;

    localparam pbcr_bctl_t PBCR_BCTL_RST = '0;
endpackage

// ==== dv/pbcr_host_model.sv ====
// axi4-lite host model standing in for the configuration requester
`timescale 1ns/1ns
module pbcr_host_model (
    // clock
    input  wire logic        sys_clk,
    // write channels
    output logic [11:0]      s_awaddr,
    output logic             s_awvalid,
    input  wire logic        s_awready,
    output logic [31:0]      s_wdata,
    output logic [3:0]       s_wstrb,
    output logic             s_wvalid,
    input  wire logic        s_wready,
    input  wire logic [1:0]  s_bresp,
    input  wire logic        s_bvalid,
    output logic             s_bready,
    // read channels
    output logic [11:0]      s_araddr,
    output logic             s_arvalid,
    input  wire logic        s_arready,
    input  wire logic [31:0] s_rdata,
    input  wire logic [1:0]  s_rresp,
    input  wire logic        s_rvalid,
    output logic             s_rready
);
    // bus idle from time zero
    initial begin
        {s_awaddr, s_awvalid, s_wdata, s_wstrb, s_wvalid, s_bready} = '0;
        {s_araddr, s_arvalid, s_rready} = '0;
    end

    // one write; each channel dropped only at the edge that takes it
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [1:0] r);
        bit ad;
        bit wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge sys_clk);
        s_awaddr  <= a;
        s_wdata   <= d;
        s_wstrb   <= s;
        s_awvalid <= 1'h1;
        s_wvalid  <= 1'h1;
        s_bready  <= 1'h1;
        while (!(ad && wd)) begin
            @(posedge sys_clk);
            if (s_awvalid && s_awready) begin
                ad = 1'b1;
                s_awvalid <= 1'h0;
            end
            if (s_wvalid && s_wready) begin
                wd = 1'b1;
                s_wvalid <= 1'h0;
            end
        end
        // no latency assumed: the bench watchdog bounds this wait
        while (!s_bvalid) @(posedge sys_clk);
        r = s_bresp;
        s_bready <= 1'h0;
    endtask

    // one read; data taken at the edge where rvalid is sampled high
    task automatic rd(input logic [11:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge sys_clk);
        s_araddr  <= a;
        s_arvalid <= 1'h1;
        s_rready  <= 1'h1;
        do @(posedge sys_clk); while (!s_arready);
        s_arvalid <= 1'h0;
        while (!s_rvalid) @(posedge sys_clk);
        d = s_rdata;
        r = s_rresp;
        s_rready <= 1'h0;
    endtask
endmodule // pbcr_host_model

// ==== dv/pcie_bridge_control_cap_regs_tb.sv ====
// self-checking bench for the bridge control register bank
`timescale 1ns/1ns
module pcie_bridge_control_cap_regs_tb;
    import pbcr_pkg::*;
    logic        sys_clk, srst, mgmt_pin_load, io_valid, io_in_window;
    logic        mem_valid, poison_seen, err_msg_in, irq, ce;
    logic [7:0]  mgmt_pin_value;
    logic [31:0] io_addr, mem_addr, s_wdata, s_rdata, rd_v;
    logic [11:0] s_awaddr, s_araddr;
    logic [3:0]  s_wstrb, port_reset;
    logic [1:0]  s_bresp, s_rresp, rsp;
    logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic s_arvalid, s_arready, s_rvalid, s_rready;
    logic io_fwd_up, io_fwd_down, vga_fwd, poison_report, err_msg_fwd;
    int   n_fail, n_tests;

    // downstream port 1, so video bits and pin override are live
    pbcr_regs #(.IS_UPSTREAM(1'b0), .PORT_NUM(1), .NUM_DS(4)) dut_u (
        .sys_clk, .srst, .ce, .s_awaddr, .s_awvalid, .s_awready,
        .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
        .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
        .s_rvalid, .s_rready, .mgmt_pin_load, .mgmt_pin_value, .io_valid,
        .io_addr, .io_in_window, .mem_valid, .mem_addr, .poison_seen,
        .err_msg_in, .io_fwd_up, .io_fwd_down, .vga_fwd, .poison_report,
        .err_msg_fwd, .port_reset, .irq);
    pbcr_host_model host_u (
        .sys_clk, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
        .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
        .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] m, e);
        host_u.rd(a, rd_v, rsp);
        chk("read data", rd_v & m, e);
        chk("read resp", {30'h0, rsp}, {30'h0, PBCR_RESP_OK});
    endtask
    task automatic wchk(input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [1:0] er);
        host_u.wr(a, d, s, rsp);
        chk("write resp", {30'h0, rsp}, {30'h0, er});
    endtask
    // one cycle of requests, outputs checked the cycle after
    task automatic dec(input logic iv, input logic [31:0] ia,
                       input logic w, mv, input logic [31:0] ma,
                       input logic ps, em, input logic [4:0] e);
        @(posedge sys_clk);
        {io_valid, io_addr, io_in_window} <= {iv, ia, w};
        {mem_valid, mem_addr, poison_seen, err_msg_in} <= {mv, ma, ps, em};
        @(posedge sys_clk);
        {io_valid, io_in_window, mem_valid, poison_seen, err_msg_in} <= '0;
        #1;
        chk("decode", {27'h0, io_fwd_up, io_fwd_down, vga_fwd,
            poison_report, err_msg_fwd}, {27'h0, e});
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // 10 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // watchdog, about thirty times the expected run
    initial begin
        #300000;
        n_fail++;
        test_done();
    end
    // main sequence
    initial begin
        n_fail = 0;
        n_tests = 0;
        srst = 1'b1;
        ce = 1'b1;
        {mgmt_pin_load, mgmt_pin_value, io_valid, io_in_window} = '0;
        {io_addr, mem_valid, mem_addr, poison_seen, err_msg_in} = '0;
        repeat (10) @(posedge sys_clk);
        srst <= 1'h0;
        rchk(12'h034, 32'h0000_00FF, 32'h0000_0080);
        rchk(12'h03C, 32'hFFFF_FFFF, 32'h0000_0000);
        rchk(12'h080, 32'h0000_FFFF, 32'h0000_8C01);
        rchk(12'h100, 32'hFFFF_FFFF, 32'h0000_0000);
        wchk(12'h034, 32'h0000_0000, 4'hF, PBCR_RESP_OK);
        rchk(12'h034, 32'h0000_00FF, 32'h0000_0080);
        // all ones: read-only and hardwired bits must stay clear
        wchk(12'h03C, 32'hFFFF_FFFF, 4'hF, PBCR_RESP_OK);
        rchk(12'h03C, 32'hFFFF_FFFF, 32'h005F_00FF);
        chk("port reset", {28'h0, port_reset}, 32'h1);
        wchk(12'h03C, 32'h0000_0000, 4'h1, PBCR_RESP_OK);
        rchk(12'h03C, 32'hFFFF_FFFF, 32'h005F_0000);
        chk("port reset", {28'h0, port_reset}, 32'h1);
        // every bridge control enable set, 16-bit video decode
        dec(1'h1, 32'h100, 1'h1, 1'h0, 32'h0, 1'h1, 1'h1, 5'h13);
        dec(1'h1, 32'h050, 1'h1, 1'h0, 32'h0, 1'h0, 1'h0, 5'h08);
        dec(1'h1, 32'h3C5, 1'h0, 1'h1, 32'h000A_0000, 1'h0, 1'h0,
            5'h0C);
        dec(1'h1, 32'h3BB, 1'h0, 1'h0, 32'h0, 1'h0, 1'h0, 5'h0C);
        dec(1'h1, 32'h3BC, 1'h0, 1'h1, 32'h000C_0000, 1'h0, 1'h0,
            5'h00);
        dec(1'h1, 32'h43C5, 1'h0, 1'h1, 32'h000B_FFFF, 1'h0, 1'h0,
            5'h04);
        // video only, 10-bit decode, reset released
        wchk(12'h03C, 32'h0008_0000, 4'h4, PBCR_RESP_OK);
        chk("port reset", {28'h0, port_reset}, 32'h0);
        dec(1'h1, 32'h43C5, 1'h0, 1'h0, 32'h0, 1'h0, 1'h0, 5'h0C);
        dec(1'h1, 32'h100, 1'h1, 1'h1, 32'h000A_0000, 1'h1, 1'h1,
            5'h0C);
        // sticky events, masked then unmasked, then cleared
        rchk(12'h100, 32'hFFFF_FFFF, 32'h0000_0007);
        chk("irq", {31'h0, irq}, 32'h0);
        wchk(12'h104, 32'h0000_0007, 4'h1, PBCR_RESP_OK);
        repeat (2) @(posedge sys_clk);
        chk("irq", {31'h0, irq}, 32'h1);
        wchk(12'h100, 32'h0000_0007, 4'h1, PBCR_RESP_OK);
        repeat (2) @(posedge sys_clk);
        chk("irq", {31'h0, irq}, 32'h0);
        rchk(12'h100, 32'hFFFF_FFFF, 32'h0000_0000);
        // unmapped place answers with an error and zero data
        host_u.rd(12'h0F0, rd_v, rsp);
        chk("unmapped data", rd_v, 32'h0);
        chk("unmapped resp", {30'h0, rsp}, {30'h0, PBCR_RESP_ERR});
        wchk(12'h0F0, 32'hFFFF_FFFF, 4'hF, PBCR_RESP_ERR);
        // management load overrides the pin byte, bus write does not
        @(posedge sys_clk);
        mgmt_pin_load  <= 1'h1;
        mgmt_pin_value <= 8'h01;
        @(posedge sys_clk);
        mgmt_pin_load <= 1'h0;
        wchk(12'h03C, 32'h0000_AA00, 4'h2, PBCR_RESP_OK);
        rchk(12'h03C, 32'hFFFF_FFFF, 32'h0008_0100);
        // enable low: a request that would decode must change nothing
        @(posedge sys_clk);
        ce <= 1'h0;
        dec(1'h1, 32'h3C5, 1'h0, 1'h1, 32'h000A_0000, 1'h0, 1'h0, 5'h00);
        @(posedge sys_clk);
        ce <= 1'h1;
        // reset in mid-run clears the loaded pin byte and bridge control
        srst <= 1'h1;
        @(posedge sys_clk);
        srst <= 1'h0;
        rchk(12'h03C, 32'hFFFF_FFFF, 32'h0000_0000);
        test_done();
    end
endmodule // pcie_bridge_control_cap_regs_tb
